// *** lps_pkg.sv ***
// Constants for the latched parallel-in / serial-out shift register.
// Assumes a core clock of 50 MHz and a free strobe-driven link clock.
// Functional notes
// - Capture strobe rise stores parallel inputs in latch
// - Select high, shift edge loads serial input first
// - Select low, serial input is ignored
// - Select high lets register shift on edges
// - Select low loads from latch, no shifting
// - Low reset clears all stages at once
// - Reset leaves latch contents untouched
// - Each shift moves every stage one onward
// - Serial output shows the final stage
// - Select low copies latch regardless of strobe
// - Capture with select low fills latch and register
// - Both strobes together with select high: capture and shift
package lps_pkg;
    localparam int             LPS_WIDTH     = 8;
    localparam int             LPS_LAST      = LPS_WIDTH - 1;
    localparam logic [7:0]     LPS_SR_RESET  = 8'h00;
    localparam logic           LPS_SEL_IDLE  = 1'b1;
    localparam int             LPS_CORE_NS   = 20;
    localparam int             LPS_LINK_NS   = 80;
    // Core cycles per link period; a crossed event settles within this
    localparam int             LPS_LINK_CYC  = LPS_LINK_NS / LPS_CORE_NS;
endpackage

// *** lps_shift_reg.sv ***
// Latched eight-stage parallel-in / serial-out shift register.
// Assumes pins come from a foreign domain and shift_clk is the link clock.
`timescale 1ns/1ps
module lps_shift_reg
    import lps_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 shift_clk,
    input  wire logic                 latch_clk,
    input  wire logic                 shift_sel,
    input  wire logic                 serial_in,
    input  wire logic [LPS_WIDTH-1:0] par_in,
    output logic                      serial_out
);

    // Link domain: sample serial input and select on each shift edge
    logic                 lk_tgl_q,  lk_tgl_d;
    logic                 lk_bit_q,  lk_bit_d;
    logic                 lk_mode_q, lk_mode_d;

    always_comb begin
        lk_tgl_d  = ~lk_tgl_q;
        lk_bit_d  = serial_in;
        lk_mode_d = shift_sel;
    end

    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_tgl_q  <= 1'b0;
            lk_bit_q  <= 1'b0;
            lk_mode_q <= 1'b0;
        end else begin
            lk_tgl_q  <= lk_tgl_d;
            lk_bit_q  <= lk_bit_d;
            lk_mode_q <= lk_mode_d;
        end
    end

    // Core domain synchronisers; first stages feed second stages only
    logic                 tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic                 lclk_s1_q, lclk_s2_q, lclk_s3_q;
    logic                 sel_s1_q, sel_s2_q;
    logic [LPS_WIDTH-1:0] par_s1_q, par_s2_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_q  <= 1'b0;
            tgl_s2_q  <= 1'b0;
            tgl_s3_q  <= 1'b0;
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
            // Idle shift level, so an unset latch is not copied as reset ends
            sel_s1_q  <= LPS_SEL_IDLE;
            sel_s2_q  <= LPS_SEL_IDLE;
            par_s1_q  <= LPS_SR_RESET;
            par_s2_q  <= LPS_SR_RESET;
        end else begin
            tgl_s1_q  <= lk_tgl_q;
            tgl_s2_q  <= tgl_s1_q;
            tgl_s3_q  <= tgl_s2_q;
            lclk_s1_q <= latch_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            sel_s1_q  <= shift_sel;
            sel_s2_q  <= sel_s1_q;
            par_s1_q  <= par_in;
            par_s2_q  <= par_s1_q;
        end
    end

    logic shift_evt;
    logic latch_rise;
    assign shift_evt  = tgl_s2_q ^ tgl_s3_q;
    assign latch_rise = lclk_s2_q & ~lclk_s3_q;

    // Input latch; deliberately not reset
    logic [LPS_WIDTH-1:0] latch_q, latch_d;

    always_comb begin
        latch_d = latch_q;
        if (latch_rise) begin
            latch_d = par_s2_q;
        end
    end

    always_ff @(posedge core_clk) begin
        latch_q <= latch_d;
    end

    // Shift register, stage A in bit 0, stage H in the top bit
    logic [LPS_WIDTH-1:0] sr_q, sr_d;

    always_comb begin
        sr_d = sr_q;
        if (!sel_s2_q) begin
            sr_d = latch_q;
            if (latch_rise) begin
                sr_d = par_s2_q;
            end
        end else if (shift_evt && lk_mode_q) begin
            sr_d = {sr_q[LPS_LAST-1:0], lk_bit_q};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= LPS_SR_RESET;
        end else begin
            sr_q <= sr_d;
        end
    end

    assign serial_out = sr_q[LPS_LAST];

    // Checks
    logic [LPS_WIDTH-1:0] shifted;
    assign shifted = {sr_q[LPS_LAST-1:0], lk_bit_q};

    a_latch_capture: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        latch_rise |=> latch_q == $past(par_s2_q))
        else $error("latch missed capture");

    a_serial_shift: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (shift_evt && lk_mode_q && sel_s2_q) |=> sr_q == $past(shifted))
        else $error("serial shift wrong");

    a_serial_ignored: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (shift_evt && !lk_mode_q && !latch_rise) |=>
            sr_q == ($past(sel_s2_q) ? $past(sr_q) : $past(latch_q)))
        else $error("serial input not ignored");

    a_idle_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (sel_s2_q && !shift_evt) |=> $stable(sr_q))
        else $error("register moved without shift");

    a_load_copy: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!sel_s2_q && !latch_rise) |=> sr_q == $past(latch_q))
        else $error("latch not copied");

    a_reset_clear: assert property (
        @(posedge core_clk)
        !rst_n |-> sr_q == LPS_SR_RESET && !serial_out)
        else $error("reset did not clear");

    a_latch_kept: assert property (
        @(posedge core_clk)
        (!rst_n && $past(!rst_n)) |-> $stable(latch_q))
        else $error("reset changed latch");

    a_output_stage: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (shift_evt && lk_mode_q && sel_s2_q) |=>
            serial_out == $past(sr_q[LPS_LAST-1]))
        else $error("output not from stage before");

    a_par_both: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (latch_rise && !sel_s2_q) |=> sr_q == $past(par_s2_q))
        else $error("capture not in both");

    a_both_strobes: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (latch_rise && shift_evt && lk_mode_q && sel_s2_q) |=>
            latch_q == $past(par_s2_q) && sr_q == $past(shifted))
        else $error("dual strobe wrong");

    a_shift_blocked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!sel_s2_q && shift_evt && !latch_rise) |=> sr_q == $past(latch_q))
        else $error("shift not blocked in load mode");

    a_sel_follow: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> sel_s2_q == $past(shift_sel, 2))
        else $error("select sync lost");

    a_reset_first: assert property (
        @(posedge core_clk)
        $rose(rst_n) |-> sr_q == LPS_SR_RESET)
        else $error("register moved during reset");

    a_event_gap: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        shift_evt |=> !shift_evt)
        else $error("shift event longer than one cycle");

    // Per stage from bit 1 up: each takes the stage before it
    for (genvar g = 1; g < LPS_WIDTH; g++) begin : g_stage
        a_stage_move: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (shift_evt && lk_mode_q && sel_s2_q) |=>
                sr_q[g] == $past(sr_q[g-1]))
            else $error("stage did not take previous stage");
    end

    c_load: cover property (@(posedge core_clk) disable iff (!rst_n)
        latch_rise && !sel_s2_q);
    c_shift: cover property (@(posedge core_clk) disable iff (!rst_n)
        shift_evt && lk_mode_q && sel_s2_q);
    c_both: cover property (@(posedge core_clk) disable iff (!rst_n)
        latch_rise && shift_evt && sel_s2_q);
    c_reset: cover property (@(posedge core_clk) $rose(rst_n));
    c_copy: cover property (@(posedge core_clk) disable iff (!rst_n)
        shift_evt && !lk_mode_q && !sel_s2_q);

endmodule

// *** lps_host.sv ***
// Host model: drives strobes, select and data into the shift register.
// Assumes core_clk runs freely and the bench calls op().
`timescale 1ns/1ps
module lps_host
    import lps_pkg::*;
(
    input  wire logic                 core_clk,
    output logic                      shift_clk,
    output logic                      latch_clk,
    output logic                      shift_sel,
    output logic                      serial_in,
    output logic [LPS_WIDTH-1:0]      par_in
);
    initial begin
        shift_clk = 1'b0;
        latch_clk = 1'b0;
        shift_sel = 1'b1;
        serial_in = 1'b0;
        par_in = 8'h00;
    end
    // One strobe round; released data turns inverted
    task automatic op(input logic sel, lat, shf, d,
                      input logic [LPS_WIDTH-1:0] v);
        @(posedge core_clk);
        par_in <= v;
        serial_in <= d;
        shift_sel <= sel;
        repeat (3) @(posedge core_clk);
        latch_clk <= lat;
        #7 shift_clk = shf;
        #40 shift_clk = 1'b0;
        @(posedge core_clk);
        latch_clk <= 1'b0;
        repeat (3) @(posedge core_clk);
        par_in <= ~v;
        serial_in <= ~d;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// *** tb_top.sv ***
// Bench for the latched shift register, host model on its pins.
// Assumes the serial output settles within each host round.
`timescale 1ns/1ps
module tb_top;
    logic        core_clk;
    logic        rst_n;
    logic        shift_clk;
    logic        latch_clk;
    logic        shift_sel;
    logic        serial_in;
    logic [7:0]  par_in;
    logic        serial_out;
    logic [7:0]  lq;
    logic [7:0]  eq;
    logic [23:0] rows [3];
    int          fails;
    int          checks;
    int          i;
    int          k;
    lps_shift_reg u_lps_shift_reg (.core_clk(core_clk), .rst_n(rst_n),
        .shift_clk(shift_clk), .latch_clk(latch_clk), .shift_sel(shift_sel),
        .serial_in(serial_in), .par_in(par_in), .serial_out(serial_out));
    lps_host u_lps_host (.core_clk(core_clk), .shift_clk(shift_clk),
        .latch_clk(latch_clk), .shift_sel(shift_sel),
        .serial_in(serial_in), .par_in(par_in));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic seen, input logic e);
        checks++;
        if (seen !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, seen, e);
        end
    endtask
    task automatic step(input logic sel, lat, shf, d, input logic [7:0] v);
        u_lps_host.op(sel, lat, shf, d, v);
        if (lat) lq = v;
        if (!sel) eq = lq;
        else if (shf) eq = {eq[6:0], d};
        chk(serial_out, eq[7]);
    endtask
    task final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        final_report;
    end
    initial begin
        rst_n = 1'b1;
        fails = 0;
        checks = 0;
        eq = 8'h00;
        lq = 8'h00;
        // Rows: latch byte, serial byte, output after each shift
        rows = '{24'hA55A52, 24'h01FFC0, 24'h80C380};
        // Clean falling edge so link flops also see reset
        #1 rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        chk(serial_out, 1'b0);
        rst_n <= 1'b1;
        step(1'b1, 1'b1, 1'b0, 1'b0, 8'h5A);
        $display("capture test done");
        for (i = 0; i < 3; i++) begin
            step(1'b0, 1'b1, 1'b0, 1'b0, rows[i][23:16]);
            chk(serial_out, rows[i][23]);
            for (k = 0; k < 8; k++) begin
                step(1'b1, 1'b0, 1'b1, rows[i][k+8], 8'h00);
                chk(serial_out, rows[i][k]);
            end
            $display("row %0d done", i);
        end
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(serial_out, 1'b0);
        u_lps_host.op(1'b0, 1'b0, 1'b1, 1'b1, 8'hFF);
        chk(serial_out, 1'b0);
        eq = 8'h00;
        rst_n <= 1'b1;
        $display("reset test done");
        step(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        step(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        step(1'b1, 1'b1, 1'b1, 1'b0, 8'h3C);
        step(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        $display("edge cases done");
        final_report;
    end
endmodule
